// ==== include/rsq_regs.vh ====
`ifndef RSQ_REGS_VH
`define RSQ_REGS_VH

// ---------------------------------------------------------------
// register indices on the plain register port
// ---------------------------------------------------------------
`define RSQ_REG_CAUSE 4'h0
`define RSQ_REG_CLKCTL 4'h1
`define RSQ_REG_PWRCFG 4'h2
`define RSQ_REG_CLKCFG 4'h3

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define RSQ_CAUSE_POR 0
`define RSQ_CAUSE_BOR 1
`define RSQ_CAUSE_WATCHDOG_EXPIRY_FLAG 4
`define RSQ_CAUSE_SWR 6
`define RSQ_CAUSE_PIN_RESET_FLAG 7
`define RSQ_CAUSE_MASK 16'h00d3
`define RSQ_CAUSE_RST 16'h0003
`define RSQ_CURSEL_LSB 12
`define RSQ_PRI_LSB 4
`define RSQ_CLOCK_FAIL_MONITOR_BIT 6
`define RSQ_PWRCFG_RST 16'h0007
`define RSQ_CLKCFG_RST 16'h0000
`define RSQ_RESET_VECTOR 24'h000000

// ---------------------------------------------------------------
// clock source selections and primary oscillator kinds
// ---------------------------------------------------------------
`define RSQ_SEL_FRC 3'h0
`define RSQ_SEL_FRCPLL 3'h1
`define RSQ_SEL_PRI 3'h2
`define RSQ_SEL_PRIPLL 3'h3
`define RSQ_SEL_SECONDARY_OSCILLATOR 3'h4
`define RSQ_SEL_LOW_POWER_INTERNAL_RC 3'h5
`define RSQ_SEL_FRCDIV16 3'h6
`define RSQ_SEL_FRCDIVN 3'h7
`define RSQ_PRI_XT 2'h0
`define RSQ_PRI_HS 2'h1
`define RSQ_PRI_EC 2'h2

// ---------------------------------------------------------------
// timing: times in their own unit, clock rate in MHz
// ---------------------------------------------------------------
// sized to the 26-bit counters; every product stays below 2^26 at
// this clock rate, a faster clock would need wider counters
`define RSQ_CLK_MHZ 26'hfa
`define RSQ_NS_PER_US 26'h3e8
`define RSQ_T_FRC_OSCD_NS 26'h44c
`define RSQ_T_LOW_POWER_INTERNAL_RC_OSCD_NS 26'h11170
`define RSQ_T_XTAL_OSCD_NS 26'h4e20
`define RSQ_T_LOCK_US 26'h5dc
`define RSQ_T_POWERUP_DELAY_TIMER_UNIT_US 26'h3e8
`define RSQ_T_POR_NS 26'h4e20
`define RSQ_T_BOR_NS 26'h4e20
`define RSQ_T_CLOCK_FAIL_MONITOR_NS 26'hfa0
`define RSQ_T_PIN_MIN_NS 26'hc8
`define RSQ_OST_PERIODS 26'h400

`endif

// ==== design/rsq_pin_filter.v ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// glitch filter for the active-low clear pin
// ---------------------------------------------------------------
module rsq_pin_filter #(
  parameter [7:0] MIN_CYC = 8'd50
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // pin side
  input wire pin_n,
  // filtered level, high while a long enough low is seen
  output reg asserted_r
);

  reg [7:0] low_cnt_r;

  // a low shorter than the minimum width never reaches the output;
  // release is immediate so the pin cannot stretch a reset
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cnt_r <= 8'h00;
      asserted_r <= 1'b0;
    end
    else if (pin_n)
    begin
      low_cnt_r <= 8'h00;
      asserted_r <= 1'b0;
    end
    else
    begin
      if (low_cnt_r != MIN_CYC)
        low_cnt_r <= low_cnt_r + 8'h01;
      asserted_r <= (low_cnt_r == MIN_CYC);
    end
  end

endmodule

`default_nettype wire

// ==== design/rsq_reset_sequencer.v ====
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.vh"

module rsq_reset_sequencer #(
  parameter [25:0] POWERUP_DELAY_TIMER_MS_CYC = `RSQ_T_POWERUP_DELAY_TIMER_UNIT_US * `RSQ_CLK_MHZ,
  parameter [25:0] LOCK_CYC = `RSQ_T_LOCK_US * `RSQ_CLK_MHZ,
  parameter [25:0] LOW_POWER_INTERNAL_RC_OSCD_CYC =
    `RSQ_T_LOW_POWER_INTERNAL_RC_OSCD_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US,
  parameter [25:0] XTAL_OSCD_CYC =
    `RSQ_T_XTAL_OSCD_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US,
  parameter [25:0] POR_CYC =
    `RSQ_T_POR_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US,
  parameter [25:0] BOR_CYC =
    `RSQ_T_BOR_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // supply detectors, high while the supply is above the threshold
  input wire power_on_threshold,
  input wire brownout_threshold,
  // external clear pin, active low
  input wire external_clear_pin,
  // other reset sources, one-cycle pulses, and the sleep_or_idle level
  input wire soft_reset_req,
  input wire watchdog_timeout,
  input wire sleep_or_idle,
  // one pulse per oscillator clock period
  input wire osc_tick,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // reset and clock outputs
  output reg master_reset_out,
  output reg osc_enable,
  output reg [2:0] current_clock_select,
  output reg clock_ready,
  output reg clock_fail_monitor,
  output reg fetch_start,
  output reg [23:0] fetch_addr,
  output reg wake_req
);

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam [3:0] ST_POR = 4'h0;
  localparam [3:0] ST_BOR = 4'h1;
  localparam [3:0] ST_POWERUP_DELAY_TIMER = 4'h2;
  localparam [3:0] ST_OSCD = 4'h3;
  localparam [3:0] ST_OST = 4'h4;
  localparam [3:0] ST_LOCK = 4'h5;
  localparam [3:0] ST_RUN = 4'h6;
  localparam [3:0] ST_HOLD = 4'h7;
  localparam [3:0] ST_SWR = 4'h8;
  localparam [25:0] FRC_OSCD_CYC =
    `RSQ_T_FRC_OSCD_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US;
  localparam [25:0] OST_CNT = `RSQ_OST_PERIODS;
  localparam [25:0] CLOCK_FAIL_MONITOR_CYC =
    `RSQ_T_CLOCK_FAIL_MONITOR_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US;
  // filter counter is 8 bits; the width is cut on purpose
  localparam [25:0] PIN_MIN_FULL =
    `RSQ_T_PIN_MIN_NS * `RSQ_CLK_MHZ / `RSQ_NS_PER_US;
  localparam [7:0] PIN_MIN_CYC = PIN_MIN_FULL[7:0];

  // ---------------------------------------------------------------
  // mode table helpers
  // ---------------------------------------------------------------
  // oscillator start-up wait applies to all but external clock
  function has_oscd;
    input [2:0] sel;
    input [1:0] pri;
    begin
      has_oscd = !((sel == `RSQ_SEL_PRI || sel == `RSQ_SEL_PRIPLL) &&
        pri == `RSQ_PRI_EC);
    end
  endfunction

  // start-up timer for crystal and secondary oscillators
  function has_ost;
    input [2:0] sel;
    input [1:0] pri;
    begin
      has_ost = sel == `RSQ_SEL_SECONDARY_OSCILLATOR ||
        ((sel == `RSQ_SEL_PRI || sel == `RSQ_SEL_PRIPLL) &&
        pri != `RSQ_PRI_EC);
    end
  endfunction

  // lock wait for the pll modes
  function has_lock;
    input [2:0] sel;
    begin
      has_lock = sel == `RSQ_SEL_FRCPLL || sel == `RSQ_SEL_PRIPLL;
    end
  endfunction

  // first clock-ready step at or after a given step
  function [3:0] osc_step;
    input [3:0] from;
    input [2:0] sel;
    input [1:0] pri;
    begin
      if (from <= ST_OSCD && has_oscd(sel, pri))
        osc_step = ST_OSCD;
      else if (from <= ST_OST && has_ost(sel, pri))
        osc_step = ST_OST;
      else if (from <= ST_LOCK && has_lock(sel))
        osc_step = ST_LOCK;
      else
        osc_step = ST_RUN;
    end
  endfunction

  // start-up delay by source
  function [25:0] oscd_cycles;
    input [2:0] sel;
    begin
      if (sel == `RSQ_SEL_LOW_POWER_INTERNAL_RC)
        oscd_cycles = LOW_POWER_INTERNAL_RC_OSCD_CYC;
      else if (sel == `RSQ_SEL_PRI || sel == `RSQ_SEL_PRIPLL ||
        sel == `RSQ_SEL_SECONDARY_OSCILLATOR)
        oscd_cycles = XTAL_OSCD_CYC;
      else
        oscd_cycles = FRC_OSCD_CYC;
    end
  endfunction

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  reg rst_meta_r;
  reg rst_n_r;

  // release is synchronised so the sequencer leaves reset cleanly
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // clear pin filter
  // ---------------------------------------------------------------
  wire pin_reset;

  rsq_pin_filter #(
    .MIN_CYC(PIN_MIN_CYC)
  ) u_pin_filter (
    .clock(clock),
    .rst_n(rst_n_r),
    .pin_n(external_clear_pin),
    .asserted_r(pin_reset)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [25:0] count_r;
  reg [25:0] count_nxt;
  reg [25:0] clock_fail_monitor_cnt_r;
  reg [15:0] cause_r;
  reg [15:0] cause_nxt;
  reg [2:0] cur_sel_r;
  reg [2:0] cur_sel_nxt;
  reg [15:0] pwrcfg_r;
  reg [15:0] clkcfg_r;
  wire [2:0] new_clock_select_cfg;
  wire [1:0] pri_kind;
  wire [2:0] powerup_delay_select;
  wire wdt_reset;
  reg [25:0] powerup_delay_timer_cyc;

  assign new_clock_select_cfg = clkcfg_r[2:0];
  assign pri_kind = clkcfg_r[`RSQ_PRI_LSB+1:`RSQ_PRI_LSB];
  assign powerup_delay_select = pwrcfg_r[2:0];
  assign wdt_reset = watchdog_timeout && !sleep_or_idle;

  // power-up period: 0, then 2 ms doubling to 128 ms
  always @*
  begin
    if (powerup_delay_select == 3'h0)
      powerup_delay_timer_cyc = 26'h0;
    else
      powerup_delay_timer_cyc = POWERUP_DELAY_TIMER_MS_CYC << powerup_delay_select;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // supply loss outranks pin and watchdog; soft reset only from run
  always @*
  begin
    state_nxt = state_r;
    count_nxt = (count_r != 26'h0) ? count_r - 26'h1 : 26'h0;
    cur_sel_nxt = cur_sel_r;
    if (!power_on_threshold)
    begin
      state_nxt = ST_POR;
      count_nxt = POR_CYC;
    end
    else if (!brownout_threshold && state_r != ST_POR)
    begin
      state_nxt = ST_BOR;
      count_nxt = BOR_CYC;
    end
    else if ((pin_reset || wdt_reset) && state_r >= ST_RUN)
    begin
      state_nxt = ST_HOLD;
    end
    else
    begin
      case (state_r)
        ST_POR:
        begin
          if (count_r == 26'h0)
          begin
            state_nxt = ST_BOR;
            count_nxt = BOR_CYC;
          end
        end
        ST_BOR:
        begin
          if (count_r == 26'h0)
          begin
            state_nxt = ST_POWERUP_DELAY_TIMER;
            count_nxt = powerup_delay_timer_cyc;
          end
        end
        ST_POWERUP_DELAY_TIMER, ST_OSCD, ST_OST, ST_LOCK:
        begin
          if (state_r == ST_OST && !osc_tick)
            count_nxt = count_r;
          if (count_r == 26'h0 ||
            (state_r == ST_OST && count_r == 26'h1 && osc_tick))
          begin
            if (state_r == ST_POWERUP_DELAY_TIMER)
              cur_sel_nxt = new_clock_select_cfg;
            state_nxt = osc_step(state_r + 4'h1,
              (state_r == ST_POWERUP_DELAY_TIMER) ? new_clock_select_cfg : cur_sel_r,
              pri_kind);
            case (state_nxt)
              ST_OSCD: count_nxt = oscd_cycles(new_clock_select_cfg);
              ST_OST: count_nxt = OST_CNT;
              ST_LOCK: count_nxt = LOCK_CYC;
              default: count_nxt = 26'h0;
            endcase
          end
        end
        ST_RUN:
        begin
          if (soft_reset_req)
            state_nxt = ST_SWR;
        end
        ST_HOLD, ST_SWR:
        begin
          state_nxt = ST_RUN;
        end
        default:
        begin
          state_nxt = ST_POR;
          count_nxt = POR_CYC;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reset cause flags
  // ---------------------------------------------------------------
  // hardware sets win over a software write in the same cycle
  always @*
  begin
    cause_nxt = cause_r;
    if (reg_wr && reg_addr == `RSQ_REG_CAUSE)
      cause_nxt = reg_wdata & `RSQ_CAUSE_MASK;
    if (state_nxt == ST_POR && state_r != ST_POR)
      cause_nxt = `RSQ_CAUSE_RST;
    else
    begin
      if (state_nxt == ST_BOR && state_r != ST_BOR && state_r != ST_POR)
      begin
        cause_nxt[`RSQ_CAUSE_BOR] = 1'b1;
        cause_nxt[`RSQ_CAUSE_SWR] = 1'b0;
        cause_nxt[`RSQ_CAUSE_WATCHDOG_EXPIRY_FLAG] = 1'b0;
      end
      if (pin_reset)
        cause_nxt[`RSQ_CAUSE_PIN_RESET_FLAG] = 1'b1;
      if (state_nxt == ST_SWR)
        cause_nxt[`RSQ_CAUSE_SWR] = 1'b1;
      if (watchdog_timeout)
        cause_nxt[`RSQ_CAUSE_WATCHDOG_EXPIRY_FLAG] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // the block's own reset stands for power-on: cold, flags at por
  always @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ST_POR;
      count_r <= POR_CYC;
      cause_r <= `RSQ_CAUSE_RST;
      cur_sel_r <= `RSQ_SEL_FRC;
      pwrcfg_r <= `RSQ_PWRCFG_RST;
      clkcfg_r <= `RSQ_CLKCFG_RST;
      clock_fail_monitor_cnt_r <= CLOCK_FAIL_MONITOR_CYC;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      cause_r <= cause_nxt;
      cur_sel_r <= cur_sel_nxt;
      if (reg_wr && reg_addr == `RSQ_REG_PWRCFG)
        pwrcfg_r <= {13'h0, reg_wdata[2:0]};
      if (reg_wr && reg_addr == `RSQ_REG_CLKCFG)
        clkcfg_r <= {9'h0, reg_wdata[6:0]};
      if (state_r != ST_RUN)
        clock_fail_monitor_cnt_r <= CLOCK_FAIL_MONITOR_CYC;
      else if (clock_fail_monitor_cnt_r != 26'h0)
        clock_fail_monitor_cnt_r <= clock_fail_monitor_cnt_r - 26'h1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // all outputs registered; watchdog reset shows one cycle after the
  // timeout pulse since the inputs are sampled on the clock
  always @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      master_reset_out <= 1'b1;
      osc_enable <= 1'b0;
      current_clock_select <= `RSQ_SEL_FRC;
      clock_ready <= 1'b0;
      clock_fail_monitor <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr <= `RSQ_RESET_VECTOR;
      wake_req <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      master_reset_out <= state_nxt != ST_RUN;
      osc_enable <= state_nxt >= ST_OSCD;
      current_clock_select <= cur_sel_nxt;
      clock_ready <= state_nxt == ST_RUN || state_nxt >= ST_HOLD;
      clock_fail_monitor <= clkcfg_r[`RSQ_CLOCK_FAIL_MONITOR_BIT] &&
        state_r == ST_RUN && clock_fail_monitor_cnt_r == 26'h0;
      fetch_start <= state_nxt == ST_RUN && state_r != ST_RUN;
      fetch_addr <= `RSQ_RESET_VECTOR;
      wake_req <= watchdog_timeout && sleep_or_idle;
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `RSQ_REG_CAUSE: reg_rdata <= cause_r;
          `RSQ_REG_CLKCTL:
            reg_rdata <= {1'b0, cur_sel_r, 12'h000};
          `RSQ_REG_PWRCFG: reg_rdata <= pwrcfg_r;
          `RSQ_REG_CLKCFG: reg_rdata <= clkcfg_r;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== verification/rsq_reset_sequencer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// port checker for the reset sequencer
// ------------------------------------------------
module rsq_seq_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // reset sources
  input wire logic power_on_threshold,
  input wire logic brownout_threshold,
  input wire logic external_clear_pin,
  input wire logic soft_reset_req,
  input wire logic watchdog_timeout,
  input wire logic sleep_or_idle,
  // outputs under watch
  input wire logic master_reset_out,
  input wire logic [2:0] current_clock_select,
  input wire logic clock_ready,
  input wire logic osc_enable,
  input wire logic clock_fail_monitor,
  input wire logic fetch_start,
  input wire logic [23:0] fetch_addr,
  input wire logic wake_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic run;
  logic [7:0] lo_cnt_r;

  // running with both supplies up and the clear pin released
  assign run = clock_ready && !master_reset_out && power_on_threshold &&
    brownout_threshold && external_clear_pin;

  // length of the present low on the clear pin, saturating
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      lo_cnt_r <= 8'h00;
    else if (external_clear_pin)
      lo_cnt_r <= 8'h00;
    else if (lo_cnt_r != 8'hff)
      lo_cnt_r <= lo_cnt_r + 8'h01;
  end

  property p_soft;
    soft_reset_req && !watchdog_timeout && run |=>
      master_reset_out ##1 (!master_reset_out && fetch_start);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset pulse shape");

  property p_warm_clk;
    soft_reset_req && run |=> ##1
      current_clock_select == $past(current_clock_select, 2);
  endproperty
  a_warm_clk: assert property (p_warm_clk)
    else $error("clock select moved on warm reset");

  property p_vector;
    fetch_start |-> fetch_addr == 24'h000000;
  endproperty
  a_vector: assert property (p_vector)
    else $error("fetch address not zero");

  property p_release;
    $fell(master_reset_out) |-> fetch_start && clock_ready;
  endproperty
  a_release: assert property (p_release)
    else $error("release without fetch");

  property p_wake;
    watchdog_timeout && sleep_or_idle && run |=>
      wake_req && !master_reset_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep timeout did not wake only");

  property p_wdt;
    watchdog_timeout && !sleep_or_idle && run |=> master_reset_out;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("timeout gave no reset");

  property p_supply;
    !power_on_threshold || !brownout_threshold |=> master_reset_out;
  endproperty
  a_supply: assert property (p_supply)
    else $error("low supply without reset");

  property p_bor_hold;
    $rose(brownout_threshold) && power_on_threshold |->
      master_reset_out [*8];
  endproperty
  a_bor_hold: assert property (p_bor_hold)
    else $error("brown-out delay cut short");

  property p_pin;
    !external_clear_pin && lo_cnt_r == 8'd55 |-> master_reset_out;
  endproperty
  a_pin: assert property (p_pin)
    else $error("long pin low gave no reset");

  property p_monitor;
    clock_fail_monitor |-> clock_ready && !master_reset_out;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("clock monitor on before clock ready");

  property p_osc_hold;
    !brownout_threshold |=> !osc_enable;
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("oscillator enabled during brown-out");
endmodule

`default_nettype wire

// ==== verification/rsq_clear_driver.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// supervisory circuit on the clear pin
// ------------------------------------------------
module rsq_clear_driver (
  // clock
  input wire logic clock,
  // bench request: hold the pin low this many cycles
  input wire logic go,
  input wire logic [7:0] low_cycles,
  // pin, board pull-up keeps it high when idle
  output wire logic external_clear_pin
);
  logic [7:0] cnt_r = 8'h00;

  // count down the low pulse; short ones probe the glitch filter
  always @(posedge clock)
  begin
    if (go)
      cnt_r <= low_cycles;
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end

  // never floating: released means pulled high
  assign external_clear_pin = (cnt_r == 8'h00);
endmodule

`default_nettype wire

// ==== verification/system_reset_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module system_reset_sequencer_tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic power_on_threshold = 1'b0;
  logic brownout_threshold = 1'b0;
  logic soft_reset_req = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic sleep_or_idle = 1'b0;
  logic osc_tick = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_go = 1'b0;
  logic [7:0] pin_len = 8'h00;
  int rst_cycles = 0;
  logic [2:0] sel;
  wire clear_pin;
  wire [15:0] reg_rdata;
  wire master_reset_out;
  wire [2:0] current_clock_select;
  wire clock_ready;
  wire clock_fail_monitor;
  wire fetch_start;
  wire [23:0] fetch_addr;
  wire wake_req;
  wire osc_enable;
  int errors = 0;
  int cmp_count = 0;

  // ------------------------------------------------
  // clock, oscillator ticks, reset watch
  // ------------------------------------------------
  always #2 clock = ~clock;

  // tick every other cycle: crystal timer takes 2048 cycles
  always @(posedge clock)
  begin
    osc_tick <= ~osc_tick;
    if (master_reset_out === 1'b1)
      rst_cycles <= rst_cycles + 1;
  end

  rsq_clear_driver sup_u (.clock(clock), .go(pin_go),
    .low_cycles(pin_len), .external_clear_pin(clear_pin));

  // short counts keep the run brief; power-on delay keeps its own length
  rsq_reset_sequencer #(.POWERUP_DELAY_TIMER_MS_CYC(26'd4), .LOCK_CYC(26'd8),
    .LOW_POWER_INTERNAL_RC_OSCD_CYC(26'd8), .XTAL_OSCD_CYC(26'd8),
    .BOR_CYC(26'd8)) dut_u (.clock(clock), .rstn(rstn),
    .power_on_threshold(power_on_threshold),
    .brownout_threshold(brownout_threshold),
    .external_clear_pin(clear_pin), .soft_reset_req(soft_reset_req),
    .watchdog_timeout(watchdog_timeout), .sleep_or_idle(sleep_or_idle),
    .osc_tick(osc_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_reset_out(master_reset_out), .osc_enable(osc_enable),
    .current_clock_select(current_clock_select),
    .clock_ready(clock_ready), .clock_fail_monitor(clock_fail_monitor),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .wake_req(wake_req));

  // ------------------------------------------------
  // access tasks
  // ------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic measure(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (master_reset_out !== 1'b0 && n < 6000);
    chk(fetch_start, 1);
  endtask

  // two brown-out dips, counted from the last recovery
  task automatic cold(input logic [15:0] cfg, input int lo);
    int n;
    wr(4'h3, cfg);
    wr(4'h0, 16'h0000);
    @(posedge clock);
    brownout_threshold <= 1'b0;
    repeat (3) @(posedge clock);
    brownout_threshold <= 1'b1;
    chk(osc_enable, 0);
    repeat (5) @(posedge clock);
    brownout_threshold <= 1'b0;
    repeat (3) @(posedge clock);
    brownout_threshold <= 1'b1;
    measure(n);
    chk(n >= lo && n <= lo + 12, 1);
    chk(current_clock_select, cfg[2:0]);
    chk(osc_enable, 1);
    rd(4'h0, 16'h0002);
  endtask

  task automatic pulse(input bit w);
    @(posedge clock);
    if (w)
      watchdog_timeout <= 1'b1;
    else
      soft_reset_req <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    soft_reset_req <= 1'b0;
    #1;
  endtask

  task stop_test;
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial
  begin
    int n;
    int base;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    rd(4'h0, 16'h0003);
    rd(4'h2, 16'h0007);
    @(posedge clock);
    power_on_threshold <= 1'b1;
    brownout_threshold <= 1'b1;
    measure(n);
    chk(n >= 5795 && n <= 5807, 1);
    chk(current_clock_select, 3'h0);
    rd(4'h9, 16'h0000);
    base = rst_cycles;
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h00d3);
    chk(rst_cycles == base, 1);
    wr(4'h2, 16'h0000);
    cold(16'h0043, 2072);
    repeat (900) @(posedge clock);
    chk(clock_fail_monitor, 0);
    repeat (200) @(posedge clock);
    chk(clock_fail_monitor, 1);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h3000);
    cold(16'h0022, 8);
    cold(16'h0023, 16);
    cold(16'h0005, 16);
    cold(16'h0004, 2064);
    cold(16'h0001, 291);
    sel = current_clock_select;
    wr(4'h0, 16'h0000);
    base = rst_cycles;
    @(posedge clock);
    pin_go <= 1'b1;
    pin_len <= 8'd40;
    @(posedge clock);
    pin_go <= 1'b0;
    repeat (60) @(posedge clock);
    chk(rst_cycles == base, 1);
    @(posedge clock);
    pin_go <= 1'b1;
    pin_len <= 8'd60;
    @(posedge clock);
    pin_go <= 1'b0;
    repeat (70) @(posedge clock);
    chk(rst_cycles != base, 1);
    rd(4'h0, 16'h0080);
    wr(4'h0, 16'h0000);
    pulse(1'b0);
    rd(4'h0, 16'h0040);
    base = rst_cycles;
    sleep_or_idle <= 1'b1;
    pulse(1'b1);
    chk(wake_req, 1);
    sleep_or_idle <= 1'b0;
    rd(4'h0, 16'h0050);
    chk(rst_cycles == base, 1);
    pulse(1'b1);
    chk(master_reset_out, 1);
    repeat (4) @(posedge clock);
    chk(current_clock_select, sel);
    stop_test();
  end

  // hang guard, well past the expected run length
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
endmodule

bind rsq_reset_sequencer rsq_seq_checker chk_u (.clock(clock),
  .rstn(rstn), .power_on_threshold(power_on_threshold),
  .brownout_threshold(brownout_threshold),
  .external_clear_pin(external_clear_pin),
  .soft_reset_req(soft_reset_req), .watchdog_timeout(watchdog_timeout),
  .sleep_or_idle(sleep_or_idle), .master_reset_out(master_reset_out),
  .current_clock_select(current_clock_select), .clock_ready(clock_ready),
  .clock_fail_monitor(clock_fail_monitor), .fetch_start(fetch_start),
  .fetch_addr(fetch_addr), .wake_req(wake_req), .osc_enable(osc_enable));

`default_nettype wire
